/* inc/icsc_pkg.sv */
// constants for the interleave clock skew control block
// What this block does
// RULE1 - input_choice bit 15: 0 routes first input to both converters, 1 second.
// RULE2 - delay_direction bit 14: 0 delays first channel clock, 1 second channel.
// RULE3 - coarse_magnitude bits 13:11 delay chosen channel about 20 ps per step.
// RULE4 - coarse_magnitude 000b gives no coarse delay; this is its reset state.
// RULE5 - software writes ones into unused low bits of both delay registers.
// RULE6 - interleave_enable 1 samples one input with both converters, else dual.
// RULE7 - auto_phase_control on overrides manual delays, drives edges 180 apart.
package icsc_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [3:0]  IDX_ENABLE       = 4'hD;
	localparam logic [3:0]  IDX_COARSE       = 4'hE;
	localparam logic [3:0]  IDX_FINE         = 4'hF;
	localparam logic [15:0] RST_ENABLE       = 16'h3FFF;
	localparam logic [15:0] RST_COARSE       = 16'h07FF;
	localparam logic [15:0] RST_FINE         = 16'h007F;
	localparam int          BIT_INPUT_CHOICE = 15;
	localparam int          BIT_DELAY_DIR    = 14;
	localparam int          MAG_HI           = 13;
	localparam int          MAG_LO           = 11;
	localparam int          BIT_ILV_ENABLE   = 15;
	localparam int          BIT_AUTO_PHASE   = 14;
	localparam int          FINE_HI          = 15;
	localparam int          FINE_LO          = 7;
	localparam int          STEP_PS          = 20;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

/* rtl/icsc_ctrl.sv */
// interleave clock skew control registers with axi4-lite slave
`timescale 1ns/100ps
module icsc_ctrl
	import icsc_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// axi4-lite write
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// converter control
	output logic             input_choice,
	output logic             interleave_enable,
	output logic             delay_first_en,
	output logic             delay_second_en,
	output logic [2:0]       coarse_magnitude,
	output logic [8:0]       fine_magnitude,
	output logic             auto_phase_control
);
	logic [15:0] enable_reg;
	logic [15:0] coarse_reg;
	logic [15:0] fine_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        aw_have_reg;
	logic        w_have_reg;

	function automatic logic [3:0] reg_index(input logic [7:0] a);
		reg_index = a[5:2];
	endfunction
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a[7:6] == 2'h0) &&
			(a[5:2] >= IDX_ENABLE);
	endfunction

	wire        wr_fire  = aw_have_reg && w_have_reg && !s_bvalid;
	wire [3:0]  wr_idx   = reg_index(awaddr_reg);
	wire        wr_ok    = mapped(awaddr_reg);
	wire [15:0] wr_val   = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
		wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};
	wire [1:0]  wr_lanes = wstrb_reg[1:0];

	// merge honours byte lanes; registers are write-only so reads give zero
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] ln);
		merge = {ln[1] ? nw[15:8] : old[15:8], ln[0] ? nw[7:0] : old[7:0]};
	endfunction

	wire [15:0] enable_next = merge(enable_reg, wr_val, wr_lanes);
	wire [15:0] coarse_next = merge(coarse_reg, wr_val, wr_lanes);
	wire [15:0] fine_next   = merge(fine_reg, wr_val, wr_lanes);
	wire        auto_on     = enable_reg[BIT_AUTO_PHASE];

	// write address and data accepted in either order
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			s_bvalid    <= 1'b0;
			s_bresp     <= RESP_OKAY;
			s_awready   <= 1'b1;
			s_wready    <= 1'b1;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg  <= s_awaddr;
				s_awready   <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg  <= s_wdata;
				wstrb_reg  <= s_wstrb;
				s_wready   <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				s_bvalid    <= 1'b1;
				s_bresp     <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				// both channels reopen only once the response is taken
				s_bvalid  <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	// unused low bits are stored as written; software keeps them at ones [RULE5]
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= RST_ENABLE;
			coarse_reg <= RST_COARSE; // [RULE4]
			fine_reg   <= RST_FINE;
		end else if (wr_fire && wr_ok) begin
			if (wr_idx == IDX_ENABLE)
				enable_reg <= enable_next;
			if (wr_idx == IDX_COARSE)
				coarse_reg <= coarse_next;
			if (wr_idx == IDX_FINE)
				fine_reg <= fine_next;
		end
	end

	// read channel: all registers write-only, mapped reads return zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= RESP_OKAY;
		end else begin
			s_arready <= 1'b0;
			if (s_arvalid && !s_arready && !s_rvalid) begin
				s_arready <= 1'b1;
				s_rvalid  <= 1'b1;
				s_rdata   <= 32'h0000_0000;
				s_rresp   <= mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// control outputs registered; auto phase zeroes manual delays
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_choice       <= 1'b0;
			interleave_enable  <= 1'b0;
			auto_phase_control <= 1'b0;
			delay_first_en     <= 1'b0;
			delay_second_en    <= 1'b0;
			coarse_magnitude   <= 3'h0;
			fine_magnitude     <= 9'h000;
		end else begin
			input_choice       <= coarse_reg[BIT_INPUT_CHOICE]; // [RULE1]
			interleave_enable  <= enable_reg[BIT_ILV_ENABLE]; // [RULE6]
			auto_phase_control <= auto_on; // [RULE7]
			delay_first_en     <= !auto_on &&
				!coarse_reg[BIT_DELAY_DIR]; // [RULE2]
			delay_second_en    <= !auto_on &&
				coarse_reg[BIT_DELAY_DIR]; // [RULE2]
			coarse_magnitude   <= auto_on ? 3'h0 :
				coarse_reg[MAG_HI:MAG_LO]; // [RULE3] [RULE7]
			fine_magnitude     <= auto_on ? 9'h000 :
				fine_reg[FINE_HI:FINE_LO]; // [RULE7]
		end
	end
endmodule

/* sim/icsc_ctrl_checker.sv */
// assertions on the skew control outputs
`timescale 1ns/100ps
module icsc_ctrl_checker (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       s_bvalid,
	input wire logic       input_choice,
	input wire logic       interleave_enable,
	input wire logic       delay_first_en,
	input wire logic       delay_second_en,
	input wire logic [2:0] coarse_magnitude,
	input wire logic [8:0] fine_magnitude,
	input wire logic       auto_phase_control
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence rst_gone; $rose(rst_n); endsequence
	// outputs lag the response by one edge
	sequence wr_done; $past(s_bvalid); endsequence
	dir_exclusive_a: assert property (
		!(delay_first_en && delay_second_en)) else $error("both delays on");
	manual_one_a: assert property (
		$past(rst_n) && !auto_phase_control |-> delay_first_en ^ delay_second_en)
		else $error("no delayed channel");
	auto_override_a: assert property (
		auto_phase_control |-> !{delay_first_en, delay_second_en,
		coarse_magnitude, fine_magnitude}) else $error("manual delay in auto");
	reset_state_a: assert property (
		rst_gone |=> !{coarse_magnitude, input_choice, interleave_enable}
		&& delay_first_en) else $error("bad state after reset");
	choice_cause_a: assert property (
		$past(rst_n) && $changed(input_choice) |-> wr_done)
		else $error("input choice moved without write");
	ilv_cause_a: assert property (
		$past(rst_n) && $changed(interleave_enable) |-> wr_done)
		else $error("interleave moved without write");
endmodule
bind icsc_ctrl icsc_ctrl_checker chk_i (.*);

/* sim/test_icsc_ctrl.sv */
// self-checking bench for the skew control block
`timescale 1ns/100ps
module test_icsc_ctrl;
	import icsc_pkg::*;
	logic		sys_clk = 1'b0, rst_n = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0;
	logic		s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0, s_bvalid;
	logic		s_awready, s_wready, s_arready, s_rvalid, input_choice;
	logic		interleave_enable, delay_first_en, delay_second_en;
	logic		auto_phase_control;
	logic [7:0]	s_awaddr = 8'h00, s_araddr = 8'h00;
	logic [31:0]	s_wdata = 32'h0, s_rdata, d;
	logic [1:0]	s_bresp, s_rresp, r;
	logic [2:0]	coarse_magnitude;
	logic [8:0]	fine_magnitude;
	int		err_count = 0, tests_run = 0;
	wire [7:0]	obs = {input_choice, interleave_enable, auto_phase_control,
			delay_first_en, delay_second_en, coarse_magnitude};
	always #12.5 sys_clk = ~sys_clk;
	icsc_ctrl uut (.*, .s_wstrb(4'hF));
	task automatic chk(input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t saw %h want %h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// request held until its ready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [15:0] v);
		int n;
		logic tb;
		n = 0;
		tb = 1'b0;
		@(posedge sys_clk);
		s_awaddr <= a;
		s_araddr <= a;
		s_wdata <= {16'hFFFF, v};
		s_awvalid <= w;
		s_wvalid <= w;
		s_bready <= w;
		s_arvalid <= !w;
		s_rready <= !w;
		while (!tb && n < 50) begin
			@(posedge sys_clk);
			n++;
			if (w ? s_awready : s_arready) begin
				s_awvalid <= 1'b0;
				s_arvalid <= 1'b0;
			end
			if (s_wready) s_wvalid <= 1'b0;
			tb = w ? s_bvalid : s_rvalid;
			r = w ? s_bresp : s_rresp;
			d = s_rdata;
		end
		s_bready <= 1'b0;
		s_rready <= 1'b0;
		if (!tb) begin
			err_count++;
			end_sim;
		end
		@(posedge sys_clk);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(obs, 8'h10);
		$display("reset test done");
		for (int k = 0; k < 8; k++) begin
			xfer(1'b1, 8'h38, {k[0], k[1], k[2:0], 11'h7FF});
			chk(obs, {k[0], 2'b00, ~k[1], k[1], k[2:0]});
		end
		$display("coarse test done");
		xfer(1'b1, 8'h3C, 16'hFFFF);
		chk(fine_magnitude, 9'h1FF);
		xfer(1'b1, 8'h34, 16'hBFFF);
		chk(obs, 8'hCF);
		xfer(1'b1, 8'h34, 16'hFFFF);
		chk({obs, fine_magnitude}, {8'hE0, 9'h000});
		$display("enable test done");
		xfer(1'b1, 8'h40, 16'h0000);
		chk({r, obs}, {RESP_SLVERR, 8'hE0});
		xfer(1'b0, 8'h38, 16'h0000);
		chk({r, d}, {RESP_OKAY, 32'h0});
		$display("bus test done");
		end_sim;
	end
endmodule
